// *** core/bas_sizer.sv ***
// Purpose: Region decode and beat splitting between core and system bus
// Assumes: Targets answer reads in the cycle bus_valid is high
// Notes: Wait selection and programming state come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
module bas_sizer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic bus_valid,
  output logic [31:0] bus_addr,
  output logic bus_write,
  output logic [1:0] bus_size,
  output logic [31:0] bus_wdata,
  output logic [3:0] bus_region,
  input wire logic [31:0] bus_rdata,
  input wire logic [1:0] flash_read_wait_sel,
  input wire logic prog_active,
  output logic prog_supply_ctl_out,
  output logic prog_supply_ctl_oe,
  output logic [31:0] vector_base_addr
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] region_of(input logic [31:0] a);
    logic [3:0] r;
    r = bas_pkg::REG_NONE;
    for (int i = 1; i < bas_pkg::BAS_NREG; i++)
    begin
      if (a >= bas_pkg::REG_FIRST[i] && a <= bas_pkg::REG_LAST[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : region_of

  function automatic logic [1:0] beat_size_of(input logic [1:0] sz,
                                             input logic [1:0] w);
    return (sz > w) ? w : sz;
  endfunction : beat_size_of

  function automatic logic [2:0] beats_of(input logic [1:0] sz,
                                         input logic [1:0] w);
    logic [2:0] n;
    n = 3'h1;
    if (sz > w)
    begin
      n = 3'h1 << (sz - w);
    end
    return n;
  endfunction : beats_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BEAT = 2'b10
  } bas_state_t;

  bas_state_t state_q;
  logic req_ready_q;
  logic rsp_valid_q;
  logic [31:0] rsp_rdata_q;
  logic bus_valid_q;
  logic [31:0] bus_addr_q;
  logic bus_write_q;
  logic [1:0] bus_size_q;
  logic [31:0] bus_wdata_q;
  logic [3:0] bus_region_q;
  logic [31:0] wdata_q;
  logic [31:0] acc_q;
  logic [1:0] beat_idx_q;
  logic [1:0] beat_last_q;
  logic [1:0] waits_q;
  logic prog_out_q;
  logic prog_oe_q;
  logic [31:0] vector_base_q;

  logic take;
  logic [3:0] req_region;
  logic [1:0] req_width;
  logic [1:0] req_bsize;
  logic [2:0] req_beats;
  logic [1:0] req_waits;
  logic beat_done;
  logic beat_last;
  logic wait_expired;
  logic timer_load;
  logic [1:0] timer_val;
  logic [4:0] cur_shift;
  logic [4:0] nxt_shift;
  logic [31:0] part;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign take = req_valid && req_ready_q;
  assign req_region = region_of(req_addr);
  assign req_width = bas_pkg::REG_WIDTH[req_region];
  assign req_bsize = beat_size_of(req_size, req_width);
  assign req_beats = beats_of(req_size, req_width);
  // Only flash reads wait; writes go to the flash controller unstretched
  assign req_waits = (req_region == bas_pkg::REG_FLASH && !req_write) ?
                     flash_read_wait_sel : 2'h0;

  assign beat_done = (state_q == ST_BEAT) && wait_expired;
  assign beat_last = (beat_idx_q == beat_last_q);
  assign timer_load = (take && req_region != bas_pkg::REG_NONE) ||
                      (beat_done && !beat_last);
  assign timer_val = take ? req_waits : waits_q;

  bas_wait_timer u_wait (
    .clk(clk),
    .reset_n(reset_n),
    .load(timer_load),
    .load_val(timer_val),
    .expired(wait_expired)
  );

  // ----------------------------------------------------------------
  // Lane steering
  // ----------------------------------------------------------------
  assign cur_shift = 5'({3'h0, beat_idx_q} << (3'h3 + {1'b0, bus_size_q}));
  assign nxt_shift = 5'({3'h0, 2'(beat_idx_q + 2'h1)}
                        << (3'h3 + {1'b0, bus_size_q}));

  always_comb
  begin
    case (bus_size_q)
      2'h0: part = {24'h0, bus_rdata[7:0]};
      2'h1: part = {16'h0, bus_rdata[15:0]};
      default: part = bus_rdata;
    endcase
    if (bus_write_q)
    begin
      part = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Handshake and sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      req_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 32'h0;
      acc_q <= 32'h0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (take && req_region == bas_pkg::REG_NONE)
          begin
            rsp_valid_q <= 1'b1;
            rsp_rdata_q <= 32'h0;
          end
          else if (take)
          begin
            state_q <= ST_BEAT;
            req_ready_q <= 1'b0;
            acc_q <= 32'h0;
          end
        end
        ST_BEAT:
        begin
          if (beat_done)
          begin
            acc_q <= acc_q | (part << cur_shift);
            if (beat_last)
            begin
              rsp_valid_q <= 1'b1;
              rsp_rdata_q <= acc_q | (part << cur_shift);
              state_q <= ST_IDLE;
              req_ready_q <= 1'b1;
            end
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          req_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus beats
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus_valid_q <= 1'b0;
      bus_addr_q <= 32'h0;
      bus_write_q <= 1'b0;
      bus_size_q <= 2'h0;
      bus_wdata_q <= 32'h0;
      bus_region_q <= bas_pkg::REG_NONE;
      wdata_q <= 32'h0;
      beat_idx_q <= 2'h0;
      beat_last_q <= 2'h0;
      waits_q <= 2'h0;
    end
    else if (take && req_region != bas_pkg::REG_NONE)
    begin
      // Unmapped accesses never reach the bus, so writes have no effect
      bus_valid_q <= 1'b1;
      bus_addr_q <= req_addr;
      bus_write_q <= req_write;
      bus_size_q <= req_bsize;
      bus_wdata_q <= req_wdata;
      bus_region_q <= req_region;
      wdata_q <= req_wdata;
      beat_idx_q <= 2'h0;
      beat_last_q <= 2'(req_beats - 3'h1);
      waits_q <= req_waits;
    end
    else if (beat_done && beat_last)
    begin
      bus_valid_q <= 1'b0;
    end
    else if (beat_done)
    begin
      beat_idx_q <= beat_idx_q + 2'h1;
      bus_addr_q <= bus_addr_q + (32'h1 << bus_size_q);
      bus_wdata_q <= wdata_q >> nxt_shift;
    end
  end

  // ----------------------------------------------------------------
  // Programming control pin and vector base
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prog_oe_q <= 1'b0;
      prog_out_q <= 1'b0;
      vector_base_q <= bas_pkg::VECTOR_BASE_RST;
    end
    else
    begin
      // Pin stays released until programming starts; no glitch at reset
      prog_oe_q <= prog_active;
      prog_out_q <= prog_active;
    end
  end

  assign req_ready = req_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign bus_valid = bus_valid_q;
  assign bus_addr = bus_addr_q;
  assign bus_write = bus_write_q;
  assign bus_size = bus_size_q;
  assign bus_wdata = bus_wdata_q;
  assign bus_region = bus_region_q;
  assign prog_supply_ctl_out = prog_out_q;
  assign prog_supply_ctl_oe = prog_oe_q;
  assign vector_base_addr = vector_base_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic is_fread;
  logic [3:0] rreg;
  assign rreg = req_region;
  assign is_fread = (rreg == bas_pkg::REG_FLASH) && !req_write;

  a_unmapped_quick: assert property (@(posedge clk) disable iff (!reset_n)
    take && rreg == bas_pkg::REG_NONE |=>
      rsp_valid && rsp_rdata == 32'h0 && !bus_valid && req_ready)
    else $error("unmapped access not answered in one cycle");

  a_wide_single: assert property (@(posedge clk) disable iff (!reset_n)
    take && rreg != bas_pkg::REG_NONE && req_width == bas_pkg::BAS_W32 &&
    !is_fread |=> bus_valid ##1 (rsp_valid && !bus_valid))
    else $error("32-bit device access took more than one beat");

  a_half_split: assert property (@(posedge clk) disable iff (!reset_n)
    take && req_width == bas_pkg::BAS_W16 && rreg != bas_pkg::REG_NONE &&
    req_size == bas_pkg::BAS_W32 |=>
      (bus_valid && !rsp_valid) [*2] ##1 rsp_valid)
    else $error("32-bit access to 16-bit device not split in two");

  a_half_narrow: assert property (@(posedge clk) disable iff (!reset_n)
    take && req_width == bas_pkg::BAS_W16 && rreg != bas_pkg::REG_NONE &&
    req_size != bas_pkg::BAS_W32 |=> bus_valid ##1 rsp_valid)
    else $error("narrow access to 16-bit device not one beat");

  a_byte_split: assert property (@(posedge clk) disable iff (!reset_n)
    take && req_width == bas_pkg::BAS_W8 && rreg != bas_pkg::REG_NONE &&
    req_size == bas_pkg::BAS_W32 |=> bus_valid [*4] ##1 rsp_valid)
    else $error("32-bit access to 8-bit device not four beats");

  a_flash_wait3: assert property (@(posedge clk) disable iff (!reset_n)
    take && is_fread && flash_read_wait_sel == 2'h3 |=>
      (bus_valid && !rsp_valid) [*4] ##1 rsp_valid)
    else $error("flash read with three waits has wrong length");

  a_flash_wait0: assert property (@(posedge clk) disable iff (!reset_n)
    take && is_fread && flash_read_wait_sel == 2'h0 |=>
      bus_valid ##1 rsp_valid)
    else $error("flash read without waits has wrong length");

  a_beat_step: assert property (@(posedge clk) disable iff (!reset_n)
    beat_done && !beat_last |=>
      bus_valid && bus_addr == $past(bus_addr) + (32'h1 << bus_size))
    else $error("next beat did not follow after one clock");

  a_periph_half: assert property (@(posedge clk) disable iff (!reset_n)
    take && req_addr[31:12] == 20'h40000 |=>
      bus_region == bas_pkg::REG_PER16 && bus_size != bas_pkg::BAS_W32)
    else $error("first peripheral area not decoded as 16-bit");

  a_trace_wide: assert property (@(posedge clk) disable iff (!reset_n)
    take && req_addr >= 32'hf020_0000 && req_addr <= 32'hf023_7fff |=>
      bus_region == bas_pkg::REG_TRACE &&
      bus_size == $past(req_size))
    else $error("trace buffer not decoded as 32-bit");

  a_prog_release: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(reset_n) |-> !prog_supply_ctl_oe)
    else $error("programming pin driven right after reset");

  a_vector_zero: assert property (@(posedge clk) disable iff (!reset_n)
    vector_base_addr == 32'h0)
    else $error("vector base is not zero");

  c_flash_waited: cover property (@(posedge clk) disable iff (!reset_n)
    take && is_fread && flash_read_wait_sel == 2'h2);
  c_half_split: cover property (@(posedge clk) disable iff (!reset_n)
    take && req_width == bas_pkg::BAS_W16 && req_size == bas_pkg::BAS_W32);
  c_unmapped: cover property (@(posedge clk) disable iff (!reset_n)
    take && rreg == bas_pkg::REG_NONE);
  c_prog_drive: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(prog_supply_ctl_oe));

endmodule : bas_sizer
`default_nettype wire

// *** pkg/bas_pkg.sv ***
// Purpose: Shared constants for the bus access sizer
// Assumes: Little-endian lanes, processor sizes 0=8, 1=16, 2=32 bits
// Notes: Region table is walked in order; last hit wins
package bas_pkg;

  // ----------------------------------------------------------------
  // Access and device widths
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BAS_W8  = 2'h0,
    BAS_W16 = 2'h1,
    BAS_W32 = 2'h2
  } bas_width_t;

  // ----------------------------------------------------------------
  // Region identifiers
  // ----------------------------------------------------------------
  localparam int BAS_NREG = 10;
  localparam logic [3:0] REG_NONE = 4'h0;
  localparam logic [3:0] REG_FLASH = 4'h1;
  localparam logic [3:0] REG_XFLASH = 4'h2;
  localparam logic [3:0] REG_RAM = 4'h3;
  localparam logic [3:0] REG_DISP = 4'h4;
  localparam logic [3:0] REG_PER16 = 4'h5;
  localparam logic [3:0] REG_PER32 = 4'h6;
  localparam logic [3:0] REG_CORE = 4'h7;
  localparam logic [3:0] REG_ROMTAB = 4'h8;
  localparam logic [3:0] REG_TRACE = 4'h9;

  // ----------------------------------------------------------------
  // Region bounds, inclusive, indexed by region id
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_FIRST [BAS_NREG] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0004_0000, 32'h2000_0000,
    32'h2040_0000, 32'h4000_0000, 32'h4000_1000, 32'he000_0000,
    32'hf000_0000, 32'hf020_0000};
  localparam logic [31:0] REG_LAST [BAS_NREG] = '{
    32'h0000_0000, 32'h0003_ffff, 32'h0013_ffff, 32'h2001_7fff,
    32'h2040_003f, 32'h4000_0fff, 32'h4000_3fff, 32'hefff_ffff,
    32'hf000_0fff, 32'hf023_7fff};
  localparam logic [1:0] REG_WIDTH [BAS_NREG] = '{
    2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] VECTOR_BASE_RST = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUS_CYCLE_PERIODS = 1;
  localparam int BUS_CYCLE_NS = BUS_CYCLE_PERIODS * CLK_PERIOD_NS;

endpackage : bas_pkg

// *** core/bas_wait_timer.sv ***
// Purpose: Down counter that stretches one bus beat by wait cycles
// Assumes: Load and count on the same clock as the sizer
// Notes: Expired is high when the current beat may complete
`timescale 1ns/1ps
`default_nettype none
module bas_wait_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [1:0] load_val,
  output logic expired
);

  logic [1:0] cnt_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_q <= 2'h0;
    end
    else if (load)
    begin
      cnt_q <= load_val;
    end
    else if (cnt_q != 2'h0)
    begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  assign expired = (cnt_q == 2'h0);

endmodule : bas_wait_timer
`default_nettype wire

// *** testbench/bas_target_model.sv ***
// Purpose: Memory and register target behind the sizer
// Assumes: Read data is combinational while bus_valid is high
// Notes: Data is derived from the beat address: address in the low lanes, its complement in the high lanes
`timescale 1ns/1ps
`default_nettype none
module bas_target_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  output logic [31:0] bus_rdata
);
  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] idle_q;

  // A released bus flips every cycle so stale data cannot pass
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      idle_q <= 32'h5a5a_a5a5;
    else
      idle_q <= ~idle_q;
  end

  always_comb
  begin
    if (bus_valid)
      bus_rdata = {~bus_addr[15:0], bus_addr[15:0]};
    else
      bus_rdata = idle_q;
  end
endmodule : bas_target_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the bus access sizer
// Assumes: Target model answers every beat at once
// Notes: Peripheral registers see 8, 16 and 32-bit accesses
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, reset_n, req_valid, req_write, prog_active;
  logic [31:0] req_addr, req_wdata, bus_rdata;
  logic [1:0] req_size, flash_read_wait_sel;
  logic req_ready, rsp_valid, bus_valid, bus_write;
  logic prog_supply_ctl_out, prog_supply_ctl_oe;
  logic [31:0] rsp_rdata, bus_addr, bus_wdata, vector_base_addr;
  logic [1:0] bus_size;
  logic [3:0] bus_region;
  logic [31:0] la, lw;
  logic [3:0] lr;
  logic lwr;
  int n_errors = 0;
  int total_checks = 0;

  bas_sizer DUT (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_size(bus_size), .bus_wdata(bus_wdata),
    .bus_region(bus_region), .bus_rdata(bus_rdata),
    .flash_read_wait_sel(flash_read_wait_sel), .prog_active(prog_active),
    .prog_supply_ctl_out(prog_supply_ctl_out),
    .prog_supply_ctl_oe(prog_supply_ctl_oe),
    .vector_base_addr(vector_base_addr));

  bas_target_model u_target (.clk(clk), .reset_n(reset_n),
    .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_rdata(bus_rdata));

  // ------------------------------------------------------------
  // Compare and closing tasks
  // ------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      n_errors++;
      $display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : check_cnt

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // One core access; counts cycles after the take and cycles with bus_valid high
  // ------------------------------------------------------------
  task automatic acc(input logic [31:0] a, input logic wr,
    input logic [1:0] sz, input logic [31:0] wd, input logic [1:0] ws,
    input int ecyc, input int ebus, input logic [31:0] erd,
    input logic [31:0] mask);
    int n;
    int nb;
    n = 0;
    nb = 0;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_addr = a;
    req_write = wr;
    req_size = sz;
    req_wdata = wd;
    flash_read_wait_sel = ws;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    forever
    begin
      n++;
      if (rsp_valid === 1'b1 || n > 20)
        break;
      if (bus_valid === 1'b1)
      begin
        nb++;
        la = bus_addr;
        lw = bus_wdata;
        lr = bus_region;
        lwr = bus_write;
      end
      @(posedge clk);
      #1;
    end
    check_cnt(n, ecyc);
    check_cnt(nb, ebus);
    check_val(rsp_rdata & mask, erd);
    if (ebus > 0)
      check_val({31'h0, lwr}, {31'h0, wr});
  endtask : acc

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check_val({31'h0, req_ready}, 32'h1);
    check_val({31'h0, rsp_valid | bus_valid}, 32'h0);
    check_val(vector_base_addr, 32'h0);
    check_val({31'h0, prog_supply_ctl_oe}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_widths();
    acc(32'h0000_0100, 1'b0, 2'h2, 32'h0, 2'h0, 2, 1, 32'hfeff_0100,
      32'hffff_ffff);
    acc(32'h0013_fffc, 1'b0, 2'h2, 32'h0, 2'h0, 2, 1, 32'h0003_fffc,
      32'hffff_ffff);
    check_val({28'h0, lr}, {28'h0, bas_pkg::REG_XFLASH});
    acc(32'h2040_003c, 1'b0, 2'h2, 32'h0, 2'h0, 3, 2, 32'h003e_003c,
      32'hffff_ffff);
    check_val(la, 32'h2040_003e);
    acc(32'h2040_0010, 1'b0, 2'h1, 32'h0, 2'h0, 2, 1, 32'h0010,
      32'hffff);
    acc(32'h4000_0ffe, 1'b0, 2'h1, 32'h0, 2'h0, 2, 1, 32'h0ffe,
      32'hffff);
    check_val({28'h0, lr}, {28'h0, bas_pkg::REG_PER16});
    acc(32'h4000_1000, 1'b0, 2'h0, 32'h0, 2'h0, 2, 1, 32'h00,
      32'hff);
    check_val({28'h0, lr}, {28'h0, bas_pkg::REG_PER32});
    acc(32'h4000_3ffc, 1'b0, 2'h2, 32'h0, 2'h0, 2, 1, 32'hc003_3ffc,
      32'hffff_ffff);
    acc(32'hf000_0ffc, 1'b0, 2'h2, 32'h0, 2'h0, 2, 1, 32'hf003_0ffc,
      32'hffff_ffff);
    check_val({28'h0, lr}, {28'h0, bas_pkg::REG_ROMTAB});
    acc(32'hf023_7ffc, 1'b0, 2'h2, 32'h0, 2'h0, 2, 1, 32'h8003_7ffc,
      32'hffff_ffff);
    check_val({28'h0, lr}, {28'h0, bas_pkg::REG_TRACE});
    $display("test widths done");
  endtask : t_widths

  task automatic t_wait();
    // Every setting is exercised; rating it is left to software
    for (int w = 0; w < 4; w++)
      acc(32'h0000_0200, 1'b0, 2'h2, 32'h0, w[1:0], 2 + w, 1 + w,
        32'hfdff_0200, 32'hffff_ffff);
    acc(32'h0000_0200, 1'b1, 2'h2, 32'h1234_5678, 2'h3, 2, 1, 32'h0,
      32'hffff_ffff);
    acc(32'h0004_0010, 1'b0, 2'h2, 32'h0, 2'h3, 2, 1, 32'hffef_0010,
      32'hffff_ffff);
    $display("test wait done");
  endtask : t_wait

  task automatic t_unmapped();
    acc(32'hf023_8000, 1'b0, 2'h2, 32'h0, 2'h0, 1, 0, 32'h0,
      32'hffff_ffff);
    acc(32'h4000_4000, 1'b0, 2'h1, 32'h0, 2'h0, 1, 0, 32'h0,
      32'hffff_ffff);
    acc(32'h1fff_fffc, 1'b1, 2'h2, 32'hdead_0001, 2'h0, 1, 0, 32'h0,
      32'hffff_ffff);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_split_write();
    acc(32'h2040_0020, 1'b1, 2'h2, 32'ha1b2_c3d4, 2'h0, 3, 2, 32'h0,
      32'hffff_ffff);
    check_val(la, 32'h2040_0022);
    check_val({16'h0, lw[15:0]}, 32'ha1b2);
    $display("test split write done");
  endtask : t_split_write

  task automatic t_prog();
    @(posedge clk);
    #1;
    prog_active = 1'b1;
    @(posedge clk);
    #1;
    check_val({30'h0, prog_supply_ctl_oe, prog_supply_ctl_out},
      32'h3);
    prog_active = 1'b0;
    @(posedge clk);
    #1;
    check_val({31'h0, prog_supply_ctl_oe}, 32'h0);
    $display("test prog pin done");
  endtask : t_prog

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever
      #(bas_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end

  initial
  begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_addr = 32'h0;
    req_write = 1'b0;
    req_size = 2'h0;
    req_wdata = 32'h0;
    flash_read_wait_sel = 2'h0;
    prog_active = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_widths();
    t_wait();
    t_unmapped();
    t_split_write();
    t_prog();
    complete_run();
  end

  // Whole run is under a hundred cycles; this leaves ample margin
  initial
  begin
    #(3000 * bas_pkg::CLK_PERIOD_NS);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
